// *** src/quadrature_fault_monitor.sv ***
// Purpose: Reversal, phase-failure and zero-speed monitor for an encoder.
// Assumes: Phases, resets, inhibit and current loss arrive asynchronously.
// Notes:   Relay-style outputs are high while energised or closed.
//
// Contract
// - Watch both phases and flag motion whose order is not forward.
// - A leading B is forward; the opposite order is reversal.
// - After reversal wait 16 to 2048 selected pulses, then drop fault output.
// - Dropped reversal output stays latched until button, reset input or power.
// - Inhibit input held high overrides reversal detection entirely.
// - Phase failure after 4 transitions on one phase without change on other.
// - Failure output closed when healthy, opens on failure, shared with loss.
// - Compare pulse frequency with threshold 10..300 Hz, switch zero-speed output.
// - Zero-speed output reacts to a threshold crossing within under 0.1 s.
// - Auxiliary differential outputs follow A and B edge for edge.
`timescale 1ns/100ps

module quadrature_fault_monitor
#(
  parameter int unsigned WIN_CYCLES = qfm_pkg::WIN_CYC
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Encoder phases
  input  wire logic             phase_a_i,
  input  wire logic             phase_b_i,
  // Control inputs, active high
  input  wire logic             latch_reset_i,
  input  wire logic             reset_button_i,
  input  wire logic             inhibit_i,
  input  wire logic             current_loss_i,
  // Register port
  input  wire qfm_pkg::reg_req_t reg_req_i,
  output logic [31:0]           reg_rdata_o,
  // Fault and speed outputs
  output logic                  reversal_ok_o,
  output logic                  phase_ok_o,
  output logic                  zero_speed_o,
  // Auxiliary differential phase outputs
  output logic                  aux_a_o,
  output logic                  aux_a_n_o,
  output logic                  aux_b_o,
  output logic                  aux_b_n_o
);
  import qfm_pkg::*;

  localparam logic [18:0] WIN_LAST = 19'(WIN_CYCLES - 1);

  mon_state_t r;
  mon_state_t n;

  // Deglitch step: returns accepted level and new run count
  function automatic logic [2:0] filt_step(logic raw, logic cur, logic [1:0] cnt);
    logic [2:0] res;
    if (raw == cur)
    begin
      res = {cur, 2'h0};
    end
    else if (cnt == FILT_LAST)
    begin
      res = {raw, 2'h0};
    end
    else
    begin
      res = {cur, 2'(cnt + 2'h1)};
    end
    return res;
  endfunction

  // Quadrature direction of one state change, A in bit 1
  function automatic dir_t dir_step(logic [1:0] prev, logic [1:0] cur);
    dir_t d;
    case ({prev, cur})
      4'b00_10, 4'b10_11, 4'b11_01, 4'b01_00: d = DIR_FWD;
      4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00: d = DIR_REV;
      default:                                d = DIR_NONE;
    endcase
    return d;
  endfunction

  // Stuck-phase watch: {fail, count} after one cycle
  function automatic logic [3:0] quiet_step(logic own_chg, logic other_chg,
                                            logic [2:0] q, logic fail);
    logic [3:0] res;
    logic [2:0] q1;
    q1 = 3'(q + 3'h1);
    if (own_chg)
    begin
      res = 4'h0;
    end
    else if (other_chg && q != QUIET_MAX)
    begin
      res = {q1 == QUIET_MAX, q1};
    end
    else
    begin
      res = {fail, q};
    end
    return res;
  endfunction

  // Pulse count that ends the reversal delay
  function automatic logic [11:0] rev_limit(logic [2:0] sel);
    return 12'(REV_BASE << sel);
  endfunction

  // Keep threshold inside the supported band
  function automatic logic [8:0] clamp_thr(logic [31:0] v);
    logic [8:0] res;
    if (v > 32'(FREQ_MAX_HZ))
    begin
      res = 9'(FREQ_MAX_HZ);
    end
    else if (v < 32'(FREQ_MIN_HZ))
    begin
      res = 9'(FREQ_MIN_HZ);
    end
    else
    begin
      res = v[8:0];
    end
    return res;
  endfunction

  // Decoded views of the current state
  logic       clr_s;
  logic       inh_s;
  logic       a_chg;
  logic       b_chg;
  logic       a_pulse;
  dir_t       step;
  logic [3:0] qa;
  logic [3:0] qb;
  logic [2:0] fa;
  logic [2:0] fb;
  logic       active_now;

  always_comb
  begin
    clr_s      = r.sync2[IDX_RST] | r.sync2[IDX_BTN];
    inh_s      = r.sync2[IDX_INH];
    a_chg      = r.pa != r.pa_q;
    b_chg      = r.pb != r.pb_q;
    a_pulse    = r.pa & ~r.pa_q;
    step       = dir_step({r.pa_q, r.pb_q}, {r.pa, r.pb});
    qa         = quiet_step(a_chg, b_chg, r.a_quiet, r.fail_a);
    qb         = quiet_step(b_chg, a_chg, r.b_quiet, r.fail_b);
    fa         = filt_step(r.sync2[IDX_A], r.pa, r.flt_a);
    fb         = filt_step(r.sync2[IDX_B], r.pb, r.flt_b);
    active_now = r.rev_active | (step == DIR_REV);
  end

  // Next-state logic for the whole monitor
  always_comb
  begin
    n = r;

    // Two-stage synchronisers; only stage two is read elsewhere
    n.sync1 = {current_loss_i, inhibit_i, reset_button_i,
               latch_reset_i, phase_b_i, phase_a_i};
    n.sync2 = r.sync1;

    // Glitch filter ahead of the decoder
    n.pa    = fa[2];
    n.flt_a = fa[1:0];
    n.pb    = fb[2];
    n.flt_b = fb[1:0];
    n.pa_q  = r.pa;
    n.pb_q  = r.pb;

    // Reversal tracking; forward motion cancels a pending reversal
    if (inh_s)
    begin
      n.rev_active = 1'b0;
      n.rev_pulses = 12'h000;
    end
    else if (step == DIR_FWD)
    begin
      n.rev_active = 1'b0;
      n.rev_pulses = 12'h000;
    end
    else if (active_now)
    begin
      n.rev_active = 1'b1;
      if (a_pulse && r.rev_pulses != rev_limit(r.delay_sel))
      begin
        n.rev_pulses = 12'(r.rev_pulses + 12'h001);
      end
      if (a_pulse && 12'(r.rev_pulses + 12'h001) == rev_limit(r.delay_sel))
      begin
        n.rev_fault = 1'b1;
      end
    end

    // Held reset releases the latch and wins over a trip in the same cycle
    if (clr_s)
    begin
      n.rev_fault  = 1'b0;
      n.rev_pulses = 12'h000;
      n.rev_active = 1'b0;
    end

    // Relay drive has its own flop so the pin never passes through an inverter
    n.rev_ok = ~n.rev_fault;

    // Stuck-phase detectors clear as soon as the quiet phase moves
    n.fail_a   = qa[3];
    n.a_quiet  = qa[2:0];
    n.fail_b   = qb[3];
    n.b_quiet  = qb[2:0];
    n.phase_ok = ~(r.fail_a | r.fail_b | r.sync2[IDX_LOSS]);

    // Gate-time frequency meter; two windows bound the response time
    if (r.win_cnt == WIN_LAST)
    begin
      n.win_cnt    = 19'h00000;
      n.edge_cnt   = {15'h0000, a_pulse};
      n.zero_speed = ({5'h00, r.edge_cnt} * 21'(HZ_PER_EDGE)) < {12'h000, r.thresh};
    end
    else
    begin
      n.win_cnt = 19'(r.win_cnt + 19'h00001);
      if (a_pulse && r.edge_cnt != 16'hffff)
      begin
        n.edge_cnt = 16'(r.edge_cnt + 16'h0001);
      end
    end

    // Auxiliary drivers taken straight from the synchronised pins
    n.aux_a  = r.sync2[IDX_A];
    n.aux_an = ~r.sync2[IDX_A];
    n.aux_b  = r.sync2[IDX_B];
    n.aux_bn = ~r.sync2[IDX_B];

    // Register writes; unmapped offsets are ignored
    if (reg_req_i.wr)
    begin
      if (reg_req_i.addr == OFS_CTRL)
      begin
        n.delay_sel = reg_req_i.wdata[CTRL_SEL_LSB +: 3];
      end
      else if (reg_req_i.addr == OFS_THRESH)
      begin
        n.thresh = clamp_thr(reg_req_i.wdata);
      end
    end

    // Register reads answer in the following cycle only
    n.rdata = 32'h00000000;
    if (reg_req_i.rd)
    begin
      if (reg_req_i.addr == OFS_CTRL)
      begin
        n.rdata = {29'h00000000, r.delay_sel};
      end
      else if (reg_req_i.addr == OFS_THRESH)
      begin
        n.rdata = {23'h000000, r.thresh};
      end
      else if (reg_req_i.addr == OFS_STATUS)
      begin
        n.rdata[ST_REV_FAULT]  = r.rev_fault;
        n.rdata[ST_FAIL_A]     = r.fail_a;
        n.rdata[ST_FAIL_B]     = r.fail_b;
        n.rdata[ST_LOSS]       = r.sync2[IDX_LOSS];
        n.rdata[ST_ZERO]       = r.zero_speed;
        n.rdata[ST_INHIBIT]    = inh_s;
        n.rdata[ST_REV_ACTIVE] = r.rev_active;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      r <= STATE_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // Outputs come straight from state flops
  assign reg_rdata_o   = r.rdata;
  assign reversal_ok_o = r.rev_ok;
  assign phase_ok_o    = r.phase_ok;
  assign zero_speed_o  = r.zero_speed;
  assign aux_a_o       = r.aux_a;
  assign aux_a_n_o     = r.aux_an;
  assign aux_b_o       = r.aux_b;
  assign aux_b_n_o     = r.aux_bn;

  // Checks on the behaviour above
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  rev_reverse_a: assert property (
    (step == DIR_REV) && !inh_s && !clr_s |=> r.rev_active)
    else $error("reverse step did not arm reversal tracking");

  fwd_cancel_a: assert property (
    (step == DIR_FWD) && !clr_s |=> !r.rev_active && r.rev_pulses == 12'h000)
    else $error("forward step did not cancel reversal");

  rev_delay_a: assert property (
    $rose(r.rev_fault) |-> $past(r.rev_pulses) == 12'(rev_limit(r.delay_sel) - 12'h001))
    else $error("reversal fault dropped at wrong pulse count");

  rev_latch_a: assert property (
    r.rev_fault && !clr_s |=> r.rev_fault && !reversal_ok_o)
    else $error("reversal latch released without reset");

  rev_clear_a: assert property (
    clr_s |=> !r.rev_fault)
    else $error("held reset did not release reversal latch");

  inh_block_a: assert property (
    inh_s ##1 inh_s |-> !$rose(r.rev_fault) && r.rev_pulses == 12'h000)
    else $error("reversal progressed while inhibited");

  stuck_set_a: assert property (
    $rose(r.fail_a) |-> $past(r.a_quiet) == 3'h3 && $past(b_chg) && !$past(a_chg))
    else $error("phase A failure not after four B transitions");

  fault_out_a: assert property (
    (r.fail_a || r.fail_b || r.sync2[IDX_LOSS]) |=> !phase_ok_o)
    else $error("shared fault output stayed closed on failure");

  speed_hold_a: assert property (
    (r.win_cnt != 19'h00000) |-> $stable(r.zero_speed))
    else $error("zero-speed output moved inside a gate window");

  aux_follow_a: assert property (
    ##1 (aux_a_o == $past(r.sync2[IDX_A])) && (aux_b_n_o == !$past(r.sync2[IDX_B])))
    else $error("auxiliary outputs do not follow the phases");

  sync_path_a: assert property (
    ##2 r.sync2[IDX_A] == $past(phase_a_i, 2))
    else $error("phase A synchroniser depth is not two");

endmodule

// *** src/qfm_pkg.sv ***
// Purpose: Shared constants and types for the quadrature fault monitor.
// Assumes: 10 MHz system clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses of 32-bit words.
package qfm_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned WIN_MS       = 40;           // Speed gate window, ms
  localparam int unsigned WIN_CYC      = CLK_HZ / 1000 * WIN_MS;
  localparam int unsigned HZ_PER_EDGE  = 1000 / WIN_MS;
  localparam int unsigned FREQ_MIN_HZ  = 10;
  localparam int unsigned FREQ_MAX_HZ  = 300;

  // Input synchroniser bit positions
  localparam int IDX_A    = 0;
  localparam int IDX_B    = 1;
  localparam int IDX_RST  = 2;
  localparam int IDX_BTN  = 3;
  localparam int IDX_INH  = 4;
  localparam int IDX_LOSS = 5;

  // Detector constants
  localparam logic [1:0]  FILT_LAST  = 2'h2;            // Three equal samples accept
  localparam logic [2:0]  QUIET_MAX  = 3'h4;            // Transitions on other phase
  localparam logic [11:0] REV_BASE   = 12'h010;         // 16 pulses at select 0

  // Register map
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int CTRL_SEL_LSB  = 0;
  localparam int ST_REV_FAULT  = 0;
  localparam int ST_FAIL_A     = 1;
  localparam int ST_FAIL_B     = 2;
  localparam int ST_LOSS       = 3;
  localparam int ST_ZERO       = 4;
  localparam int ST_INHIBIT    = 5;
  localparam int ST_REV_ACTIVE = 6;
  localparam logic [2:0] SEL_RST    = 3'h0;
  localparam logic [8:0] THRESH_RST = 9'h00a;

  typedef enum logic [1:0] {DIR_NONE, DIR_FWD, DIR_REV} dir_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Whole state of the monitor
  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [1:0]  flt_a;
    logic [1:0]  flt_b;
    logic        pa;
    logic        pb;
    logic        pa_q;
    logic        pb_q;
    logic        rev_active;
    logic [11:0] rev_pulses;
    logic        rev_fault;
    logic        rev_ok;
    logic [2:0]  a_quiet;
    logic [2:0]  b_quiet;
    logic        fail_a;
    logic        fail_b;
    logic        phase_ok;
    logic [18:0] win_cnt;
    logic [15:0] edge_cnt;
    logic        zero_speed;
    logic        aux_a;
    logic        aux_an;
    logic        aux_b;
    logic        aux_bn;
    logic [2:0]  delay_sel;
    logic [8:0]  thresh;
    logic [31:0] rdata;
  } mon_state_t;

  localparam mon_state_t STATE_RST = '{rev_ok:     1'b1,
                                       phase_ok:   1'b1,
                                       zero_speed: 1'b1,
                                       aux_an:     1'b1,
                                       aux_bn:     1'b1,
                                       delay_sel:  SEL_RST,
                                       thresh:     THRESH_RST,
                                       default:    '0};

endpackage

// *** testbench/quad_encoder_model.sv ***
// Purpose: Behavioural incremental encoder driving the two phases.
// Assumes: One step per step_i pulse; caller spaces steps well apart.
// Notes:   hold_a_i freezes phase A to mimic a stuck channel.
`timescale 1ns/100ps
module quad_encoder_model
(
  // Clock
  input  wire logic clk_i,
  // Step control
  input  wire logic step_i,
  input  wire logic fwd_i,
  input  wire logic hold_a_i,
  // Phases
  output logic      phase_a_o,
  output logic      phase_b_o
);
  logic [1:0] pos_reg;
  logic [1:0] pos_next;

  initial
  begin
    pos_reg   = 2'h0;
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
  end

  // Gray position; counting up makes A lead B
  assign pos_next = fwd_i ? pos_reg + 2'h1 : pos_reg - 2'h1;

  // Lines move just after the edge; a held A ignores the position
  always @(posedge clk_i)
  begin
    if (step_i)
    begin
      pos_reg   <= pos_next;
      phase_b_o <= pos_next[1];
      if (!hold_a_i)
        phase_a_o <= pos_next[1] ^ pos_next[0];
    end
    else if (!hold_a_i)
      phase_a_o <= pos_reg[1] ^ pos_reg[0];
  end
endmodule

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the quadrature fault monitor.
// Assumes: 10 MHz clock, short speed window to keep the run brief.
// Notes:   Encoder steps are 12 clocks apart, above the filter minimum.
`timescale 1ns/100ps
module tb_top;
  import qfm_pkg::*;
  localparam int unsigned WIN = 400;

  logic        clk_i  = 1'b0;
  logic        srst_i = 1'b1;
  logic        step   = 1'b0;
  logic        fwd    = 1'b1;
  logic        hold_a = 1'b0;
  logic        lat    = 1'b0;
  logic        btn    = 1'b0;
  logic        inh    = 1'b0;
  logic        loss   = 1'b0;
  reg_req_t    req    = '0;
  logic [31:0] rdata;
  logic        rev_ok, ph_ok, zero, aa, aan, ab, abn, pa, pb;
  int          mismatches = 0;
  int          samples_checked = 0;

  quad_encoder_model enc (.clk_i(clk_i), .step_i(step), .fwd_i(fwd), .hold_a_i(hold_a),
                          .phase_a_o(pa), .phase_b_o(pb));

  quadrature_fault_monitor #(.WIN_CYCLES(WIN)) DUT (
    .clk_i(clk_i), .srst_i(srst_i), .phase_a_i(pa), .phase_b_i(pb),
    .latch_reset_i(lat), .reset_button_i(btn), .inhibit_i(inh), .current_loss_i(loss),
    .reg_req_i(req), .reg_rdata_o(rdata), .reversal_ok_o(rev_ok), .phase_ok_o(ph_ok),
    .zero_speed_o(zero), .aux_a_o(aa), .aux_a_n_o(aan), .aux_b_o(ab), .aux_b_n_o(abn));

  // Free-running system clock
  always #50 clk_i = ~clk_i;

  // Arguments are copied at the call, so callers must pass settled values
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One encoder step per pass, held one clock, then a quiet gap
  task steps(input int n, input logic dir);
    repeat (n)
    begin
      @(posedge clk_i);
      step <= 1'b1;
      fwd  <= dir;
      @(posedge clk_i);
      step <= 1'b0;
      tick(10);
    end
  endtask

  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task t_regs;
    check({rev_ok, ph_ok, zero}, 32'h7);
    check({aa, aan, ab, abn}, 32'h5);
    reg_rd(OFS_CTRL, 32'h0);
    reg_rd(OFS_STATUS, 32'h010);
    reg_rd(8'h0c, 32'h0);
    reg_wr(OFS_THRESH, 32'h005);
    reg_rd(OFS_THRESH, 32'h00a);
    reg_wr(OFS_THRESH, 32'h190);
    reg_rd(OFS_THRESH, 32'h12c);
    reg_wr(OFS_THRESH, 32'h00a);
  endtask

  task t_aux;
    repeat (4)
    begin
      steps(1, 1'b1);
      check({aa, aan, ab, abn}, {pa, ~pa, pb, ~pb});
    end
  endtask

  task t_speed;
    steps(84, 1'b1);
    check(zero, 1'b0);
    check(rev_ok, 1'b1);
    reg_wr(OFS_THRESH, 32'h12c);
    steps(72, 1'b1);
    check(zero, 1'b1);
    reg_wr(OFS_THRESH, 32'h00a);
    steps(72, 1'b1);
    check(zero, 1'b0);
    tick(2 * WIN + 20);
    check(zero, 1'b1);
  endtask

  // Stop one pulse short, then trip on the boundary pulse; release by reset input at select 0, by button otherwise
  task t_rev(input int sel);
    reg_wr(OFS_CTRL, sel);
    steps((16 << sel) * 4 - 4, 1'b0);
    check(rev_ok, 1'b1);
    reg_rd(OFS_STATUS, 32'h040);
    steps(4, 1'b0);
    check(rev_ok, 1'b0);
    reg_rd(OFS_STATUS, 32'h041);
    steps(8, 1'b1);
    check(rev_ok, 1'b0);
    @(posedge clk_i);
    if (sel == 0)
      lat <= 1'b1;
    else
      btn <= 1'b1;
    tick(5);
    lat <= 1'b0;
    btn <= 1'b0;
    tick(10);
    check(rev_ok, 1'b1);
  endtask

  // Shortest delay, so twenty reverse pulses would trip without the inhibit
  task t_inhibit;
    reg_wr(OFS_CTRL, 32'h0);
    @(posedge clk_i);
    inh <= 1'b1;
    tick(5);
    steps(80, 1'b0);
    check(rev_ok, 1'b1);
    reg_rd(OFS_STATUS, 32'h020);
    inh <= 1'b0;
    steps(8, 1'b1);
  endtask

  // A frozen: one B move since A last moved, so the sixth step is the fourth B move
  task t_fail;
    @(posedge clk_i);
    hold_a <= 1'b1;
    steps(5, 1'b1);
    check(ph_ok, 1'b1);
    steps(1, 1'b1);
    check(ph_ok, 1'b0);
    steps(2, 1'b1);
    check(ph_ok, 1'b0);
    @(posedge clk_i);
    hold_a <= 1'b0;
    steps(1, 1'b1);
    check(ph_ok, 1'b1);
    steps(3, 1'b1);
    @(posedge clk_i);
    loss <= 1'b1;
    tick(10);
    check(ph_ok, 1'b0);
    loss <= 1'b0;
    tick(10);
    check(ph_ok, 1'b1);
  endtask

  task wrap_up;
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    tick(8);
    srst_i <= 1'b0;
    tick(3);
    t_regs();
    t_aux();
    t_speed();
    t_rev(0);
    t_rev(1);
    t_inhibit();
    t_fail();
    wrap_up();
  end

  // Watchdog: about five times the expected run
  initial
  begin
    #4_000_000;
    mismatches++;
    wrap_up();
  end
endmodule
